// [common/srp_pkg.sv]
/*
 * srp_pkg: constants, types and register map of the receive power and
 * link pll control register bank.
 * assumes: 15-bit register addresses, 8-bit registers, one core clock.
 */
package srp_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // register addresses
    localparam logic [14:0] ADDR_MASTER_PD  = 15'h0200;
    localparam logic [14:0] ADDR_LANE_PD    = 15'h0201;
    localparam logic [14:0] ADDR_SYNC_PD    = 15'h0203;
    localparam logic [14:0] ADDR_RECOV_RST  = 15'h0206;
    localparam logic [14:0] ADDR_RECOV_MODE = 15'h0230;
    localparam logic [14:0] ADDR_EQ_BIAS    = 15'h0268;
    localparam logic [14:0] ADDR_PLL_CTRL   = 15'h0280;
    localparam logic [14:0] ADDR_PLL_STATUS = 15'h0281;

    // reset values
    localparam logic [7:0] RST_MASTER_PD  = 8'h01;
    localparam logic [7:0] RST_LANE_PD    = 8'h00;
    localparam logic [7:0] RST_SYNC_PD    = 8'h00;
    localparam logic [7:0] RST_RECOV_RST  = 8'h01;
    localparam logic [7:0] RST_RECOV_MODE = 8'h28;
    localparam logic [7:0] RST_EQ_BIAS    = 8'h62;
    localparam logic [7:0] RST_PLL_CTRL   = 8'h00;
    localparam logic [7:0] READ_NONE      = 8'h00;

    // field positions
    localparam int BIT_MASTER_PD = 0;
    localparam int LANE_PD_MSB   = 3;
    localparam int BIT_SYNC_PD   = 1;
    localparam int BIT_RECOV_RSTN = 0;
    localparam int BIT_HALF_RATE = 5;
    localparam int BIT_OVERSAMP  = 1;
    localparam int BIT_SWING     = 0;
    localparam int EQ_PWR_MSB    = 7;
    localparam int EQ_PWR_LSB    = 6;
    localparam int BIT_PLL_RECAL = 2;
    localparam int BIT_PLL_EN    = 0;
    localparam int BIT_PLL_LOCK  = 0;

    // serial frame: read flag, 15 address bits, then 8 data bits
    localparam logic [4:0] INSTR_LAST = 5'h0F;
    localparam logic [4:0] DATA_LAST  = 5'h07;
    localparam logic [4:0] CNT_ZERO   = 5'h00;
    localparam logic [4:0] CNT_ONE    = 5'h01;

    typedef enum logic [1:0] {
        SPI_IDLE  = 2'b00,
        SPI_INSTR = 2'b01,
        SPI_DATA  = 2'b10,
        SPI_DONE  = 2'b11
    } srp_spi_state_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } srp_wr_t;

    typedef struct packed {
        logic       receiver_master_power_down;
        logic [3:0] lane_power_down_bits;
        logic       sync_buffer_off;
        logic       recovery_reset_n;
        logic       half_rate_recovery_en;
        logic       input_oversample_en;
        logic       sync_output_swing_sel;
        logic [1:0] equalizer_power_sel;
        logic       link_pll_en;
        logic       link_pll_recal;
    } srp_ctrl_t;

endpackage : srp_pkg

// [hdl/srp_regs.sv]
/*
 * srp_regs: serial-port register bank for receiver power-down, clock
 * recovery modes, equalizer power and link pll enable/recalibration.
 * assumes: serial clock at most core_clk/8, 4-wire port, one byte per frame.
 */
// What this block does
// - a four-bit field powers down each lane's receive phy, reset zero.
// - bit 1 of the sync buffer register powers down the sync output buffer, reset zero.
// - recovery logic is held in reset while the active-low bit is 0; it resets to 1.
// - bit 0 of the mode register picks sync swing, 0 for about 170 mV, 1 for 350 mV.
// - bits 7:6 pick equalizer power, 00 normal, 01 low power, reset 0x1.
// - a 0 to 1 change of pll control bit 2 starts one link pll calibration.
// - pll control bit 0 enables the link pll, reset 0; it does not start a calibration.
// - the master bit powers down the whole receiver analog, reset 1.
// - a read-only status bit shows link pll lock, low out of reset.
module srp_regs
    import srp_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // serial control port pins
    input  wire logic      spi_cs_n,
    input  wire logic      spi_sclk,
    input  wire logic      spi_sdi,
    output      logic      spi_sdo,
    output      logic      spi_sdo_oe,
    // analog status
    input  wire logic      link_pll_lock_in,
    // controls to the receiver
    output      srp_ctrl_t ctrl
);

    logic           cs_s1, cs_s2;
    logic           sclk_s1, sclk_s2, sclk_s3;
    logic           sdi_s1, sdi_s2;
    logic           lock_s1, lock_s2;
    logic           sclk_rise, sclk_fall;
    srp_spi_state_t state;
    logic [4:0]     bit_cnt;
    logic [14:0]    instr_shift;
    logic           op_read;
    logic [14:0]    op_addr;
    logic [7:0]     wr_shift;
    logic [7:0]     rd_shift;
    srp_wr_t        wr;
    logic [7:0]     master_pd_reg;
    logic [7:0]     lane_pd_reg;
    logic [7:0]     sync_pd_reg;
    logic [7:0]     recov_rst_reg;
    logic [7:0]     recov_mode_reg;
    logic [7:0]     eq_mode_reg;
    logic [7:0]     pll_ctrl_reg;
    logic [14:0]    next_addr;

    // pins are asynchronous to core_clk
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            sdi_s1  <= 1'b0;
            sdi_s2  <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            cs_s1   <= spi_cs_n;
            cs_s2   <= cs_s1;
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sdi_s1  <= spi_sdi;
            sdi_s2  <= sdi_s1;
            lock_s1 <= link_pll_lock_in;
            lock_s2 <= lock_s1;
        end
    end

    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;
    assign next_addr = {instr_shift[13:0], sdi_s2};

    // lock is read from the second flop, so a read never sees a metastable bit
    function automatic logic [7:0] read_mux(input logic [14:0] a);
        logic [7:0] d;
        d = READ_NONE;
        unique case (a)
            ADDR_MASTER_PD:  d = master_pd_reg;
            ADDR_LANE_PD:    d = lane_pd_reg;
            ADDR_SYNC_PD:    d = sync_pd_reg;
            ADDR_RECOV_RST:  d = recov_rst_reg;
            ADDR_RECOV_MODE: d = recov_mode_reg;
            ADDR_EQ_BIAS:    d = eq_mode_reg;
            ADDR_PLL_CTRL:   d = pll_ctrl_reg;
            ADDR_PLL_STATUS: d[BIT_PLL_LOCK] = lock_s2;
            default:         d = READ_NONE;
        endcase
        return d;
    endfunction : read_mux

    // frame sequencer; chip select high aborts any frame
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state   <= SPI_IDLE;
            bit_cnt <= CNT_ZERO;
        end else if (cs_s2) begin
            state   <= SPI_IDLE;
            bit_cnt <= CNT_ZERO;
        end else begin
            unique case (state)
                SPI_IDLE: begin
                    state   <= SPI_INSTR;
                    bit_cnt <= CNT_ZERO;
                end
                SPI_INSTR: begin
                    if (sclk_rise) begin
                        if (bit_cnt == INSTR_LAST) begin
                            state   <= SPI_DATA;
                            bit_cnt <= CNT_ZERO;
                        end else begin
                            bit_cnt <= bit_cnt + CNT_ONE;
                        end
                    end
                end
                SPI_DATA: begin
                    if (sclk_rise) begin
                        if (bit_cnt == DATA_LAST) begin
                            state <= SPI_DONE;
                        end
                        bit_cnt <= bit_cnt + CNT_ONE;
                    end
                end
                SPI_DONE: begin
                    // bits past the 24th are ignored; the frame waits here for chip select
                    state <= SPI_DONE;
                end
            endcase
        end
    end

    // instruction capture
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            instr_shift <= '0;
            op_read     <= 1'b0;
            op_addr     <= '0;
        end else if (state == SPI_INSTR && sclk_rise) begin
            instr_shift <= next_addr;
            if (bit_cnt == INSTR_LAST) begin
                op_read <= instr_shift[14];
                op_addr <= next_addr;
            end
        end
    end

    // write data capture; only a full byte makes a write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_shift <= '0;
            wr       <= '0;
        end else begin
            wr.en <= 1'b0;
            if (!cs_s2 && state == SPI_DATA && sclk_rise) begin
                wr_shift <= {wr_shift[6:0], sdi_s2};
                if (bit_cnt == DATA_LAST && !op_read) begin
                    wr.en   <= 1'b1;
                    wr.addr <= op_addr;
                    wr.data <= {wr_shift[6:0], sdi_s2};
                end
            end
        end
    end

    // read data: loaded after the last address bit, shifted out on falling edges
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_shift   <= '0;
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            spi_sdo_oe <= !cs_s2 && op_read && (state == SPI_DATA || state == SPI_DONE);
            if (state == SPI_INSTR && sclk_rise && bit_cnt == INSTR_LAST) begin
                rd_shift <= read_mux(next_addr);
            end else if (state == SPI_DATA && sclk_fall && op_read) begin
                spi_sdo  <= rd_shift[7];
                rd_shift <= {rd_shift[6:0], 1'b0};
            end
        end
    end

    // register file; every bit, reserved ones too, is stored as written
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            master_pd_reg  <= RST_MASTER_PD;
            lane_pd_reg    <= RST_LANE_PD;
            sync_pd_reg    <= RST_SYNC_PD;
            recov_rst_reg  <= RST_RECOV_RST;
            recov_mode_reg <= RST_RECOV_MODE;
            eq_mode_reg    <= RST_EQ_BIAS;
            pll_ctrl_reg   <= RST_PLL_CTRL;
        end else if (wr.en) begin
            unique case (wr.addr)
                ADDR_MASTER_PD:  master_pd_reg  <= wr.data;
                ADDR_LANE_PD:    lane_pd_reg    <= wr.data;
                ADDR_SYNC_PD:    sync_pd_reg    <= wr.data;
                ADDR_RECOV_RST:  recov_rst_reg  <= wr.data;
                ADDR_RECOV_MODE: recov_mode_reg <= wr.data;
                ADDR_EQ_BIAS:    eq_mode_reg    <= wr.data;
                ADDR_PLL_CTRL:   pll_ctrl_reg   <= wr.data;
                default:         master_pd_reg  <= master_pd_reg;
            endcase
        end
    end

    // controls other than recal follow the registers one cycle later; recal is set from the write itself; all come straight from flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl                            <= '0;
            ctrl.receiver_master_power_down <= RST_MASTER_PD[BIT_MASTER_PD];
            ctrl.recovery_reset_n           <= RST_RECOV_RST[BIT_RECOV_RSTN];
            ctrl.half_rate_recovery_en      <= RST_RECOV_MODE[BIT_HALF_RATE];
            ctrl.equalizer_power_sel        <= RST_EQ_BIAS[EQ_PWR_MSB:EQ_PWR_LSB];
        end else begin
            ctrl.receiver_master_power_down <= master_pd_reg[BIT_MASTER_PD];
            ctrl.lane_power_down_bits       <= lane_pd_reg[LANE_PD_MSB:0];
            ctrl.sync_buffer_off            <= sync_pd_reg[BIT_SYNC_PD];
            ctrl.recovery_reset_n           <= recov_rst_reg[BIT_RECOV_RSTN];
            ctrl.half_rate_recovery_en      <= recov_mode_reg[BIT_HALF_RATE];
            ctrl.input_oversample_en        <= recov_mode_reg[BIT_OVERSAMP];
            ctrl.sync_output_swing_sel      <= recov_mode_reg[BIT_SWING];
            ctrl.equalizer_power_sel        <= eq_mode_reg[EQ_PWR_MSB:EQ_PWR_LSB];
            ctrl.link_pll_en                <= pll_ctrl_reg[BIT_PLL_EN];
            // a rewrite of 1 over 1 is no edge, so it cannot restart calibration
            ctrl.link_pll_recal <= wr.en && wr.addr == ADDR_PLL_CTRL
                && wr.data[BIT_PLL_RECAL] && !pll_ctrl_reg[BIT_PLL_RECAL];
        end
    end

    lane_pd_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.lane_power_down_bits == $past(lane_pd_reg[LANE_PD_MSB:0]))
        else $error("lane power-down output does not follow its register");

    lane_wr_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_LANE_PD)
            |=> ##1 ctrl.lane_power_down_bits == $past(wr.data[LANE_PD_MSB:0], 2))
        else $error("lane power-down output does not follow a write");

    sync_off_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_SYNC_PD)
            |=> ##1 ctrl.sync_buffer_off == $past(wr.data[BIT_SYNC_PD], 2))
        else $error("sync buffer power-down does not follow a write");

    recov_rst_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_RECOV_RST && !wr.data[BIT_RECOV_RSTN])
            |=> ##1 !ctrl.recovery_reset_n)
        else $error("recovery logic not held in reset after clearing the bit");

    swing_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.sync_output_swing_sel == $past(recov_mode_reg[BIT_SWING]))
        else $error("sync swing select does not follow mode register bit 0");

    eq_power_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.equalizer_power_sel == $past(eq_mode_reg[EQ_PWR_MSB:EQ_PWR_LSB]))
        else $error("equalizer power mode does not follow bits 7:6");

    pll_recal_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.link_pll_recal |-> $past(wr.en && wr.addr == ADDR_PLL_CTRL
            && wr.data[BIT_PLL_RECAL] && !pll_ctrl_reg[BIT_PLL_RECAL])
            ##1 !ctrl.link_pll_recal)
        else $error("recalibration pulse without a rising edge or longer than one cycle");

    recal_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_PLL_CTRL && !wr.data[BIT_PLL_RECAL])
            |=> !ctrl.link_pll_recal)
        else $error("calibration started although the recalibration bit was written 0");

    recal_edge_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_PLL_CTRL && wr.data[BIT_PLL_RECAL]
            && !pll_ctrl_reg[BIT_PLL_RECAL]) |=> ctrl.link_pll_recal)
        else $error("rising recalibration bit did not start a calibration");

    pll_en_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_PLL_CTRL)
            |=> ##1 ctrl.link_pll_en == $past(wr.data[BIT_PLL_EN], 2))
        else $error("pll enable does not follow the written bit");

    master_pd_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.receiver_master_power_down == $past(master_pd_reg[BIT_MASTER_PD]))
        else $error("master power-down output does not follow its register");

    lock_sync_a: assert property (@(posedge core_clk) disable iff (rst)
        lock_s2 == $past(link_pll_lock_in, 2))
        else $error("lock status is not the input delayed by two flops");

    reserved_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_EQ_BIAS) |=> eq_mode_reg == $past(wr.data))
        else $error("equalizer register did not store the written byte");

endmodule : srp_regs

// [verif/tb_top.sv]
/*
 * tb_top: self-checking bench for the receive power and link pll register bank.
 * assumes: srp_pkg compiled first; the serial port is driven by the bench
 * at falling core_clk edges, five core cycles per sclk phase.
 */
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top
    import srp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [14:0] REG_ADDR [7] = '{ADDR_MASTER_PD, ADDR_LANE_PD, ADDR_SYNC_PD,
        ADDR_RECOV_RST, ADDR_RECOV_MODE, ADDR_EQ_BIAS, ADDR_PLL_CTRL};
    localparam logic [7:0]  REG_RST  [7] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h28, 8'h62, 8'h00};
    // patterns model a low lane rate: oversampling on, half rate off
    // mode sets reserved bits to 0x48, bias keeps reserved bits at 0x22
    localparam logic [7:0]  REG_PAT  [7] = '{8'hAA, 8'h5A, 8'hC6, 8'h3C, 8'h4B, 8'h22, 8'h01};

    logic      core_clk = 1'b0;
    logic      rst;
    logic      spi_cs_n;
    logic      spi_sclk;
    logic      spi_sdi;
    logic      spi_sdo;
    logic      spi_sdo_oe;
    logic      link_pll_lock_in;
    srp_ctrl_t ctrl;
    int        n_errors;
    int        check_count;
    int        recal_cnt;
    logic [7:0] rd;

    srp_regs u_dut (
        .core_clk         (core_clk),
        .rst              (rst),
        .spi_cs_n         (spi_cs_n),
        .spi_sclk         (spi_sclk),
        .spi_sdi          (spi_sdi),
        .spi_sdo          (spi_sdo),
        .spi_sdo_oe       (spi_sdo_oe),
        .link_pll_lock_in (link_pll_lock_in),
        .ctrl             (ctrl)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // the recal output is a one-cycle pulse, so it is counted rather than sampled
    always @(posedge core_clk) begin
        if (ctrl.link_pll_recal === 1'b1) recal_cnt++;
    end

    function automatic srp_ctrl_t exp_ctrl(input logic [7:0] v [7]);
        srp_ctrl_t c;
        c.receiver_master_power_down = v[0][0];
        c.lane_power_down_bits       = v[1][3:0];
        c.sync_buffer_off            = v[2][1];
        c.recovery_reset_n           = v[3][0];
        c.half_rate_recovery_en      = v[4][5];
        c.input_oversample_en        = v[4][1];
        c.sync_output_swing_sel      = v[4][0];
        c.equalizer_power_sel        = v[5][7:6];
        c.link_pll_en                = v[6][0];
        c.link_pll_recal             = 1'b0;
        return c;
    endfunction : exp_ctrl

    // one frame: read flag, 15 address bits, 8 data bits, all msb first
    task automatic xfer(input logic rd_n_wr, input logic [14:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rd_n_wr, addr, wdat};
        rdat = 8'h00;
        @(negedge core_clk) spi_cs_n = 1'b0;
        repeat (4) @(negedge core_clk);
        for (int i = 23; i >= 0; i--) begin
            spi_sdi  = frame[i];
            spi_sclk = 1'b0;
            repeat (5) @(negedge core_clk);
            if (i < 8) rdat[i] = spi_sdo;
            if (i == 0) `CHK(spi_sdo_oe, rd_n_wr)
            spi_sclk = 1'b1;
            repeat (5) @(negedge core_clk);
        end
        spi_sclk = 1'b0;
        repeat (4) @(negedge core_clk);
        spi_cs_n = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK(spi_sdo_oe, 1'b0)
    endtask : xfer

    task automatic t_reset_values();
        `CHK(ctrl, exp_ctrl(REG_RST))
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, REG_ADDR[i], 8'h00, rd);
            `CHK(rd, REG_RST[i])
        end
    endtask : t_reset_values

    task automatic t_write_read();
        for (int i = 0; i < 7; i++) xfer(1'b0, REG_ADDR[i], REG_PAT[i], rd);
        `CHK(ctrl, exp_ctrl(REG_PAT))
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, REG_ADDR[i], 8'h00, rd);
            `CHK(rd, REG_PAT[i])
        end
        xfer(1'b0, ADDR_EQ_BIAS, 8'h62, rd);
        `CHK(ctrl.equalizer_power_sel, 2'b01)
    endtask : t_write_read

    task automatic t_recal();
        recal_cnt = 0;
        xfer(1'b0, ADDR_PLL_CTRL, 8'h05, rd);
        `CHK(recal_cnt, 1)
        `CHK(ctrl.link_pll_en, 1'b1)
        // writing 1 over a stored 1 must not start another calibration
        xfer(1'b0, ADDR_PLL_CTRL, 8'h05, rd);
        `CHK(recal_cnt, 1)
        xfer(1'b0, ADDR_PLL_CTRL, 8'h01, rd);
        `CHK(recal_cnt, 1)
        xfer(1'b0, ADDR_PLL_CTRL, 8'h04, rd);
        `CHK(recal_cnt, 2)
        `CHK(ctrl.link_pll_en, 1'b0)
    endtask : t_recal

    task automatic t_status();
        link_pll_lock_in = 1'b1;
        repeat (10) @(negedge core_clk);
        xfer(1'b1, ADDR_PLL_STATUS, 8'h00, rd);
        `CHK(rd, 8'h01)
        xfer(1'b0, ADDR_PLL_STATUS, 8'hFE, rd);
        xfer(1'b1, ADDR_PLL_STATUS, 8'h00, rd);
        `CHK(rd, 8'h01)
        link_pll_lock_in = 1'b0;
        repeat (10) @(negedge core_clk);
        xfer(1'b1, ADDR_PLL_STATUS, 8'h00, rd);
        `CHK(rd, 8'h00)
        // unmapped space stores nothing and reads zero
        xfer(1'b0, 15'h0202, 8'hFF, rd);
        xfer(1'b1, 15'h0202, 8'h00, rd);
        `CHK(rd, 8'h00)
    endtask : t_status

    task automatic t_rerst();
        @(negedge core_clk) rst = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(ctrl, exp_ctrl(REG_RST))
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        xfer(1'b1, ADDR_RECOV_MODE, 8'h00, rd);
        `CHK(rd, 8'h28)
    endtask : t_rerst

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        link_pll_lock_in = 1'b0;
        n_errors = 0;
        check_count = 0;
        recal_cnt = 0;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset_values();
        t_write_read();
        t_recal();
        t_status();
        t_rerst();
        wrap_up();
    end

    // about 35 frames of roughly 260 cycles each; allow generous margin
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end

endmodule : tb_top
